//--- hw/pmrc_regs.svh
// constants for the power-mode and reset control block
// assumes inclusion by bare name from the hw/ folder
`ifndef PMRC_REGS_SVH
`define PMRC_REGS_SVH
`define PMC_ADDR          8'h87
`define PMC_RESET         8'h00
`define PMC_IDLE_BIT      0
`define PMC_PDOWN_BIT     1
`define PMC_FLAG_LO_BIT   2
`define PMC_FLAG_HI_BIT   3
`define PMC_MON_BIT       4
`define PMC_BAUD_BIT      7
`define PMC_WMASK         8'h8f
`define OSC_PER_MC        4'd12
`define PH_PER_MC         4'd6
`define RST_QUAL_MC       2'd2
`define SP_RESET          8'h07
`define PORT_RESET        8'hff
`define PC_RESET          16'h0000
`define ZERO8             8'h00
`endif

//--- hw/pmrc_pkg.sv
// types for the power-mode and reset control block
// assumes nothing beyond the constants header
package pmrc_pkg;
   typedef enum {MODE_RUN, MODE_IDLE, MODE_PDOWN} pmode_t;
   typedef logic [7:0] byte_t;
endpackage

//--- hw/pmrc_if.sv
// link between the top module and its reset qualifier
// assumes one clock shared by both ends
`timescale 1ns/1ns
interface pmrc_if;
   logic mc_tick;
   logic rst_pin;
   logic int_req;
   logic core_reset;
   logic ext_reset;
   modport top (output mc_tick, output rst_pin, output int_req,
                input core_reset, input ext_reset);
   modport qual (input mc_tick, input rst_pin, input int_req,
                 output core_reset, output ext_reset);
endinterface

//--- hw/phase_divider.sv
// oscillator divide-by-two and machine-cycle tick generator
// assumes REF_CLK is the oscillator and RST asynchronous
`timescale 1ns/1ns
`include "pmrc_regs.svh"
module phase_divider (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic run,
   output logic      phase_en,
   output logic      mc_tick
);
   logic       half_reg;
   logic [3:0] ph_reg;
   logic       wrap;
   assign wrap     = (ph_reg == `PH_PER_MC - 4'd1);
   assign phase_en = run & half_reg;
   assign mc_tick  = phase_en & wrap;
   // divide-by-two, no duty cycle dependence
   always_ff @(posedge clk or posedge rst) begin
      if (rst) half_reg <= 1'b0;
      else if (run) half_reg <= ~half_reg;
   end
   // six phases of two periods per machine cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) ph_reg <= 4'd0;
      else if (phase_en) ph_reg <= wrap ? 4'd0 : ph_reg + 4'd1;
   end
endmodule

//--- hw/reset_qualifier.sv
// reset pin qualification in machine cycles
// assumes rst_pin synchronous and mc_tick one cycle per machine cycle
`timescale 1ns/1ns
`include "pmrc_regs.svh"
module reset_qualifier (
   input  wire logic clk,
   input  wire logic rst,
   pmrc_if.qual      lnk
);
   logic [1:0] cnt_reg;
   logic       hit;
   assign hit = (cnt_reg >= `RST_QUAL_MC - 2'd1);
   // count machine cycles with pin high
   always_ff @(posedge clk or posedge rst) begin
      if (rst) cnt_reg <= 2'd0;
      else if (!lnk.rst_pin) cnt_reg <= 2'd0;
      else if (lnk.mc_tick && !hit) cnt_reg <= cnt_reg + 2'd1;
   end
   // reset from second high cycle, repeated until pin low
   assign lnk.ext_reset  = lnk.rst_pin & hit;
   assign lnk.core_reset = lnk.ext_reset | lnk.int_req;
   property p_qual;
      @(posedge clk) disable iff (rst)
      !lnk.rst_pin |=> !lnk.ext_reset;
   endproperty
   a_qual: assert property (p_qual)
      else $error("reset held after pin low");

   property p_tworun;
      @(posedge clk) disable iff (rst)
      $rose(lnk.rst_pin) |-> !lnk.ext_reset;
   endproperty
   a_tworun: assert property (p_tworun)
      else $error("reset taken in first cycle");
endmodule

//--- hw/power_mode_and_reset_control.sv
// power-mode register, idle and power-down control, reset sequencing
// assumes a core that writes 8-bit registers by address and a strobe
`timescale 1ns/1ns
`include "pmrc_regs.svh"
// Overview of operation
// - idle bit set gates the core clock; peripherals keep running.
// - power-down bit set stops the oscillator and all clocked logic.
// - both bits written together choose power-down.
// - register resets to zero, bits 6 and 5 read zero.
// - the idle-setting write is the last core step; state is kept.
// - an enabled interrupt clears idle; core resumes after the write.
// - bits 2 and 3 are plain software flags.
// - idle also ends by reset held two machine cycles.
// - power-down ends only by a reset (pin, watchdog underflow or RST); contents kept.
// - monitor enable sets by write, clears only by external reset.
// - bit 7 doubles the serial baud rate in modes 1 to 3.
// - idle: strobes high, pulse outputs float, port 2 drives address with external program.
// - power-down: strobes low, pulse outputs float, port 2 holds latch.
// - pin high two machine cycles gives internal reset, strobes inputs.
// - internal reset from second high cycle, repeats until pin low.
// - watchdog underflow or enabled supply fail forces internal reset.
// - reset loads zero, stack pointer 07h, ports all ones, pc zero.
// - reset leaves internal ram unchanged.
// - after reset fetch starts at address zero.
// - static design tolerates a stopped clock without state loss.
// - oscillator passes through a divide-by-two before use.
// - internal resets keep monitor enable; monitor off in idle.
module power_mode_and_reset_control
   import pmrc_pkg::*;
(
   input  wire logic       REF_CLK,
   input  wire logic       RST,
   input  wire logic       RST_PIN,
   input  wire logic [7:0] SFR_ADDR,
   input  wire logic       SFR_WR,
   input  wire logic [7:0] SFR_WDATA,
   output logic      [7:0] SFR_RDATA,
   input  wire logic       INT_PENDING,
   input  wire logic       WDT_UNDERFLOW,
   input  wire logic       SUPPLY_FAIL,
   input  wire logic       EXT_PROGRAM,
   input  wire logic [7:0] P2_LATCH,
   input  wire logic [7:0] P2_ADDR,
   input  wire logic       ALE_RUN,
   input  wire logic       PROGRAM_FETCH_STROBE_RUN,
   output logic            CPU_CLK_EN,
   output logic            PERIPH_CLK_EN,
   output logic            OSC_RUN,
   output logic            PHASE_EN,
   output logic            MC_TICK,
   output logic            CORE_RESET,
   output logic            BAUD_DOUBLER,
   output logic            MONITOR_ACTIVE,
   output logic            ALE_O,
   output logic            ALE_OE,
   output logic            PROGRAM_FETCH_STROBE_O,
   output logic            PROGRAM_FETCH_STROBE_OE,
   output logic            P0_FLOAT,
   output logic [7:0]      P2_DRIVE,
   output logic            PULSE_FLOAT,
   output logic [7:0]      SP_INIT,
   output logic [7:0]      PORT_INIT,
   output logic [15:0]     PC_INIT,
   output logic [7:0]      ZERO_INIT
);
   import pmrc_pkg::*;

   pmrc_if lnk ();

   pmode_t mode_reg;
   pmode_t mode_next;
   logic   baud_reg;
   logic   mon_reg;
   logic   flag_lo_reg;
   logic   flag_hi_reg;
   logic   pmc_wr;
   logic   wr_idle;
   logic   wr_pdown;
   logic   mc_tick;
   logic   phase_en;
   logic   osc_on;
   logic   in_idle;
   logic   in_pdown;
   logic   sf_reset;
   byte_t  pmc_value;

   function automatic logic addr_hit(input logic [7:0] a);
      addr_hit = (a == `PMC_ADDR);
   endfunction

   assign pmc_wr   = SFR_WR & addr_hit(SFR_ADDR) & (mode_reg == MODE_RUN);
   assign wr_idle  = pmc_wr & SFR_WDATA[`PMC_IDLE_BIT];
   assign wr_pdown = pmc_wr & SFR_WDATA[`PMC_PDOWN_BIT];
   assign in_idle  = (mode_reg == MODE_IDLE);
   assign in_pdown = (mode_reg == MODE_PDOWN);

   // oscillator halts in power-down; the reset pin frees it
   assign osc_on = ~in_pdown | RST_PIN;

   phase_divider u_div (
      .clk      (REF_CLK),
      .rst      (RST),
      .run      (osc_on),
      .phase_en (phase_en),
      .mc_tick  (mc_tick)
   );

   // supply fail only with monitor on and not in idle
   assign sf_reset    = SUPPLY_FAIL & mon_reg & ~in_idle & ~in_pdown;
   assign lnk.mc_tick = mc_tick;
   assign lnk.rst_pin = RST_PIN;
   assign lnk.int_req = WDT_UNDERFLOW | sf_reset;

   reset_qualifier u_qual (
      .clk (REF_CLK),
      .rst (RST),
      .lnk (lnk)
   );

   // mode sequencing
   always_comb begin
      mode_next = mode_reg;
      case (mode_reg)
         MODE_RUN: begin
            if (wr_pdown) mode_next = MODE_PDOWN;
            else if (wr_idle) mode_next = MODE_IDLE;
         end
         MODE_IDLE: begin
            if (INT_PENDING) mode_next = MODE_RUN;
         end
         MODE_PDOWN: mode_next = MODE_PDOWN;
         default: mode_next = MODE_RUN;
      endcase
      if (lnk.core_reset) mode_next = MODE_RUN;
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) mode_reg <= MODE_RUN;
      else mode_reg <= mode_next;
   end

   // register bits; reset clears all but monitor on internal reset
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         baud_reg    <= 1'b0;
         flag_lo_reg <= 1'b0;
         flag_hi_reg <= 1'b0;
      end else if (lnk.core_reset) begin
         baud_reg    <= 1'b0;
         flag_lo_reg <= 1'b0;
         flag_hi_reg <= 1'b0;
      end else if (pmc_wr) begin
         baud_reg    <= SFR_WDATA[`PMC_BAUD_BIT];
         flag_lo_reg <= SFR_WDATA[`PMC_FLAG_LO_BIT];
         flag_hi_reg <= SFR_WDATA[`PMC_FLAG_HI_BIT];
      end
   end

   // monitor enable: set by write, cleared by external reset only
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) mon_reg <= 1'b0;
      else if (pmc_wr && SFR_WDATA[`PMC_MON_BIT]) mon_reg <= 1'b1;
      else if (lnk.ext_reset) mon_reg <= 1'b0;
   end

   // idle and power-down bits read from the mode; bits 6, 5 zero
   assign pmc_value = {baud_reg, 2'b00, mon_reg, flag_hi_reg,
                       flag_lo_reg, in_pdown, in_idle};

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) SFR_RDATA <= `ZERO8;
      else SFR_RDATA <= addr_hit(SFR_ADDR) ? pmc_value : `ZERO8;
   end

   // clock gating: core frozen in idle, all frozen in power-down
   assign CPU_CLK_EN    = phase_en & (mode_reg == MODE_RUN);
   assign PERIPH_CLK_EN = phase_en;
   assign OSC_RUN       = osc_on;
   assign PHASE_EN      = phase_en;
   assign MC_TICK       = mc_tick;
   assign CORE_RESET    = lnk.core_reset;
   assign BAUD_DOUBLER  = baud_reg;
   assign MONITOR_ACTIVE = mon_reg & ~in_idle & ~in_pdown;

   // pin states per mode; strobes released during reset
   assign ALE_OE  = ~lnk.core_reset;
   assign PROGRAM_FETCH_STROBE_OE = ~lnk.core_reset;
   assign ALE_O   = in_idle ? 1'b1 : (in_pdown ? 1'b0 : ALE_RUN);
   assign PROGRAM_FETCH_STROBE_O  = in_idle ? 1'b1 : (in_pdown ? 1'b0 : PROGRAM_FETCH_STROBE_RUN);
   assign PULSE_FLOAT = in_idle | in_pdown;
   assign P0_FLOAT    = (in_idle | in_pdown) & EXT_PROGRAM;
   assign P2_DRIVE    = (in_idle & EXT_PROGRAM) ? P2_ADDR : P2_LATCH;

   // reset load values for the core
   assign SP_INIT   = `SP_RESET;
   assign PORT_INIT = `PORT_RESET;
   assign PC_INIT   = `PC_RESET;
   assign ZERO_INIT = `ZERO8;

   property p_pd_wins;
      @(posedge REF_CLK) disable iff (RST)
      (wr_idle && wr_pdown && !lnk.core_reset) |=> in_pdown;
   endproperty
   a_pd_wins: assert property (p_pd_wins)
      else $error("idle chosen over power-down");

   property p_idle_in;
      @(posedge REF_CLK) disable iff (RST)
      (wr_idle && !wr_pdown && !lnk.core_reset) |=>
      in_idle && !CPU_CLK_EN;
   endproperty
   a_idle_in: assert property (p_idle_in)
      else $error("idle not entered");

   property p_wake;
      @(posedge REF_CLK) disable iff (RST)
      (in_idle && INT_PENDING) |=> mode_reg == MODE_RUN;
   endproperty
   a_wake: assert property (p_wake)
      else $error("interrupt did not end idle");

   property p_pd_hold;
      @(posedge REF_CLK) disable iff (RST)
      (in_pdown && !lnk.core_reset) |=> in_pdown;
   endproperty
   a_pd_hold: assert property (p_pd_hold)
      else $error("power-down left without reset");

   property p_pd_osc;
      @(posedge REF_CLK) disable iff (RST)
      (in_pdown && !RST_PIN) |-> !OSC_RUN && !PHASE_EN;
   endproperty
   a_pd_osc: assert property (p_pd_osc)
      else $error("oscillator running in power-down");

   property p_pd_free;
      @(posedge REF_CLK) disable iff (RST)
      (in_pdown && RST_PIN) |-> OSC_RUN;
   endproperty
   a_pd_free: assert property (p_pd_free)
      else $error("reset pin did not free the oscillator");

   property p_mon_keep;
      @(posedge REF_CLK) disable iff (RST)
      (mon_reg && !lnk.ext_reset) |=> mon_reg;
   endproperty
   a_mon_keep: assert property (p_mon_keep)
      else $error("monitor enable lost");

   property p_mon_off;
      @(posedge REF_CLK) disable iff (RST)
      (in_idle || in_pdown) |-> !MONITOR_ACTIVE && !sf_reset;
   endproperty
   a_mon_off: assert property (p_mon_off)
      else $error("supply monitor active while stopped");

   property p_idle_pins;
      @(posedge REF_CLK) disable iff (RST)
      in_idle |-> ALE_O && PROGRAM_FETCH_STROBE_O && PULSE_FLOAT;
   endproperty
   a_idle_pins: assert property (p_idle_pins)
      else $error("idle pin state wrong");

   property p_pd_pins;
      @(posedge REF_CLK) disable iff (RST)
      in_pdown |-> !ALE_O && !PROGRAM_FETCH_STROBE_O && P2_DRIVE == P2_LATCH;
   endproperty
   a_pd_pins: assert property (p_pd_pins)
      else $error("power-down pin state wrong");

   property p_strobe_in;
      @(posedge REF_CLK) disable iff (RST)
      lnk.core_reset |-> !ALE_OE && !PROGRAM_FETCH_STROBE_OE;
   endproperty
   a_strobe_in: assert property (p_strobe_in)
      else $error("strobes driven during reset");

   property p_wdt;
      @(posedge REF_CLK) disable iff (RST)
      WDT_UNDERFLOW |-> CORE_RESET;
   endproperty
   a_wdt: assert property (p_wdt)
      else $error("watchdog reset missing");

   property p_sreset;
      @(posedge REF_CLK) disable iff (RST)
      lnk.core_reset |=> !baud_reg && !flag_lo_reg && !flag_hi_reg;
   endproperty
   a_sreset: assert property (p_sreset)
      else $error("register bits kept through reset");

   property p_refuse;
      @(posedge REF_CLK) disable iff (RST)
      (in_idle && SFR_WR && !lnk.core_reset) |=>
      $stable(baud_reg) && $stable(flag_lo_reg) && $stable(flag_hi_reg);
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("register changed while idle");

   property p_flags;
      @(posedge REF_CLK) disable iff (RST)
      (pmc_wr && !lnk.core_reset) |=>
      flag_lo_reg == $past(SFR_WDATA[`PMC_FLAG_LO_BIT]);
   endproperty
   a_flags: assert property (p_flags)
      else $error("flag bit not stored");

   c_idle: cover property (@(posedge REF_CLK) in_idle ##1 !in_idle);
   c_pdown: cover property (@(posedge REF_CLK) in_pdown ##1 !in_pdown);
   c_both: cover property (@(posedge REF_CLK) wr_idle && wr_pdown);
   c_ext: cover property (@(posedge REF_CLK) lnk.ext_reset);
   c_pd_pin: cover property (@(posedge REF_CLK) in_pdown && lnk.ext_reset);
endmodule

//--- dv/core_model.sv
// far-side model: external reset source and interrupt logic
// assumes the bench clock and falling-edge driving
`timescale 1ns/1ns
module core_model (
   input  wire logic clk,
   output logic      rst_pin,
   output logic      int_pending
);
   initial begin
      rst_pin     = 1'b0;
      int_pending = 1'b0;
   end
   // pin level; the bench holds it high long enough
   task automatic drive_pin(input logic v);
      @(negedge clk);
      rst_pin = v;
   endtask
   // enabled interrupt pending level
   task automatic drive_int(input logic v);
      @(negedge clk);
      int_pending = v;
   endtask
endmodule

//--- dv/power_mode_and_reset_control_test.sv
// bench for the power-mode and reset control block
// assumes the hw/ package and a core model in dv/
`timescale 1ns/1ns
module power_mode_and_reset_control_test;
   import pmrc_pkg::*;
   logic        ref_clk, rst, sfr_wr, wdt_uf, supply_fail, ext_program;
   logic        ale_run, program_fetch_strobe_run, cpu_clk_en, periph_clk_en, osc_run;
   logic        phase_en, mc_tick, core_reset, baud_doubler, mon_act;
   logic        ale_o, ale_oe, program_fetch_strobe_o, program_fetch_strobe_oe, p0_float, pulse_float;
   logic        rst_pin, int_pending;
   byte_t       sfr_addr, sfr_wdata, sfr_rdata, p2_latch, p2_addr;
   byte_t       p2_drive, sp_init, port_init, zero_init;
   logic [15:0] pc_init;
   int          errors, check_count, k;

   power_mode_and_reset_control u_power_mode_and_reset_control (
      .REF_CLK(ref_clk), .RST(rst), .RST_PIN(rst_pin),
      .SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr), .SFR_WDATA(sfr_wdata),
      .SFR_RDATA(sfr_rdata), .INT_PENDING(int_pending),
      .WDT_UNDERFLOW(wdt_uf), .SUPPLY_FAIL(supply_fail),
      .EXT_PROGRAM(ext_program), .P2_LATCH(p2_latch), .P2_ADDR(p2_addr),
      .ALE_RUN(ale_run), .PROGRAM_FETCH_STROBE_RUN(program_fetch_strobe_run), .CPU_CLK_EN(cpu_clk_en),
      .PERIPH_CLK_EN(periph_clk_en), .OSC_RUN(osc_run),
      .PHASE_EN(phase_en), .MC_TICK(mc_tick), .CORE_RESET(core_reset),
      .BAUD_DOUBLER(baud_doubler), .MONITOR_ACTIVE(mon_act),
      .ALE_O(ale_o), .ALE_OE(ale_oe), .PROGRAM_FETCH_STROBE_O(program_fetch_strobe_o), .PROGRAM_FETCH_STROBE_OE(program_fetch_strobe_oe),
      .P0_FLOAT(p0_float), .P2_DRIVE(p2_drive), .PULSE_FLOAT(pulse_float),
      .SP_INIT(sp_init), .PORT_INIT(port_init), .PC_INIT(pc_init),
      .ZERO_INIT(zero_init));

   core_model u_core_model (
      .clk(ref_clk), .rst_pin(rst_pin), .int_pending(int_pending));

   always #10 ref_clk = ~ref_clk;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input byte_t a, input byte_t d);
      @(negedge ref_clk);
      sfr_addr  = a;
      sfr_wdata = d;
      sfr_wr    = 1'b1;
      @(negedge ref_clk);
      sfr_wr = 1'b0;
   endtask

   task automatic rdchk(input byte_t a, input byte_t exp);
      @(negedge ref_clk);
      sfr_addr = a;
      @(negedge ref_clk);
      check(sfr_rdata, exp);
   endtask

   // pulses of a level seen at falling edges over cyc cycles
   task automatic cnt(ref logic s, input int cyc, output int n);
      n = 0;
      repeat (cyc) begin
         @(negedge ref_clk);
         if (s === 1'b1) n++;
      end
   endtask

   // cycles until the core reset shows, limited to 30
   task automatic wait_core_reset(output int n);
      n = 0;
      while (core_reset !== 1'b1 && n < 30) begin
         @(negedge ref_clk);
         n++;
      end
   endtask

   task automatic finish_test();
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      #(20 * 5000);
      errors++;
      finish_test();
   end

   initial begin
      {ref_clk, sfr_wr, wdt_uf, supply_fail, ale_run, program_fetch_strobe_run} = '0;
      rst = 1'b1;
      ext_program = 1'b1;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      p2_latch = 8'ha5;
      p2_addr = 8'h5a;
      repeat (20) @(negedge ref_clk);
      rst = 1'b0;
      rdchk(8'h87, 8'h00);
      rdchk(8'h88, 8'h00);
      check({sp_init, port_init}, 16'h07ff);
      check(pc_init, 16'h0000);
      check(zero_init, 8'h00);
      cnt(mc_tick, 120, k);
      check(k, 10);
      cnt(phase_en, 24, k);
      check(k, 12);
      cnt(cpu_clk_en, 24, k);
      check(k, 12);
      supply_fail = 1'b1;
      @(negedge ref_clk);
      check(core_reset, 1'b0);
      supply_fail = 1'b0;
      wr(8'h87, 8'h8c);
      rdchk(8'h87, 8'h8c);
      check(baud_doubler, 1'b1);
      {ale_run, program_fetch_strobe_run} = 2'b10;
      @(negedge ref_clk);
      check({ale_o, program_fetch_strobe_o, ale_oe, program_fetch_strobe_oe}, 4'b1011);
      wr(8'h87, 8'h70);
      rdchk(8'h87, 8'h10);
      wr(8'h87, 8'h00);
      rdchk(8'h87, 8'h10);
      check(mon_act, 1'b1);
      supply_fail = 1'b1;
      @(negedge ref_clk);
      check(core_reset, 1'b1);
      supply_fail = 1'b0;
      // idle: core stopped, peripherals run, write refused
      wr(8'h87, 8'h11);
      check({osc_run, ale_o, program_fetch_strobe_o, p0_float, pulse_float}, 5'h1f);
      check(p2_drive, 8'h5a);
      ext_program = 1'b0;
      @(negedge ref_clk);
      check({p0_float, p2_drive}, 9'h0a5);
      ext_program = 1'b1;
      check(mon_act, 1'b0);
      cnt(cpu_clk_en, 24, k);
      check(k, 0);
      cnt(periph_clk_en, 24, k);
      check(k, 12);
      rdchk(8'h87, 8'h11);
      wr(8'h87, 8'h8c);
      u_core_model.drive_int(1'b1);
      u_core_model.drive_int(1'b0);
      rdchk(8'h87, 8'h10);
      // power-down with both bits, interrupt cannot wake
      wr(8'h87, 8'h03);
      check({osc_run, ale_o, program_fetch_strobe_o, p0_float, pulse_float}, 5'h03);
      check(p2_drive, 8'ha5);
      cnt(mc_tick, 24, k);
      check(k, 0);
      u_core_model.drive_int(1'b1);
      u_core_model.drive_int(1'b0);
      @(negedge ref_clk);
      check(osc_run, 1'b0);
      wdt_uf = 1'b1;
      @(negedge ref_clk);
      check(core_reset, 1'b1);
      wdt_uf = 1'b0;
      repeat (2) @(negedge ref_clk);
      check(osc_run, 1'b1);
      rdchk(8'h87, 8'h10);
      // pin reset out of idle
      wr(8'h87, 8'h01);
      u_core_model.drive_pin(1'b1);
      wait_core_reset(k);
      check(k <= 13, 1'b1);
      check({ale_oe, program_fetch_strobe_oe}, 2'b00);
      repeat (24) @(negedge ref_clk);
      check(core_reset, 1'b1);
      u_core_model.drive_pin(1'b0);
      @(negedge ref_clk);
      check(core_reset, 1'b0);
      rdchk(8'h87, 8'h00);
      // power-down left by the reset pin
      wr(8'h87, 8'h12);
      check(osc_run, 1'b0);
      u_core_model.drive_pin(1'b1);
      @(negedge ref_clk);
      check(osc_run, 1'b1);
      wait_core_reset(k);
      check(k <= 13, 1'b1);
      u_core_model.drive_pin(1'b0);
      @(negedge ref_clk);
      check({osc_run, core_reset}, 2'b10);
      rdchk(8'h87, 8'h00);
      finish_test();
   end
endmodule
